// File: rtl/usbirq_top.sv
// Purpose: Interrupt enables, device address filter and event flags for two USB device instances
// Assumes: All inputs synchronous to clock; endpoint outcome inputs are one-cycle pulses
// Notes: Registers reached over the host processor port at fixed offsets
`timescale 1ns/1ps
`default_nettype none
`include "usbirq_map.svh"

module usbirq_top
  import usbirq_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Host processor port
  input wire usbirq_word_t reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire usbirq_word_t reg_wdata,
  output usbirq_word_t reg_rdata,
  // Token address filter
  input wire logic [1:0] tok_valid,
  input wire usbirq_addr_t tok_addr_dev1,
  input wire usbirq_addr_t tok_addr_dev2,
  output logic [1:0] tok_match,
  // Endpoint transaction outcomes
  input wire usbirq_ep_t ep_num_dev1,
  input wire usbirq_ep_t ep_num_dev2,
  input wire logic [1:0] ep_ack,
  input wire logic [1:0] ep_stall,
  input wire logic [1:0] ep_timeout,
  input wire logic [1:0] ep_in_err,
  input wire logic [1:0] ep_out_err,
  input wire logic [1:0] ep_nak,
  input wire logic [7:0] nak_irq_en_dev1,
  input wire logic [7:0] nak_irq_en_dev2,
  // Bus events
  input wire logic [1:0] sof_eop_rx,
  input wire logic [1:0] bus_reset_det,
  // OTG inputs of the first port A
  input wire logic vbus_valid,
  input wire logic otg_id,
  // Interrupt requests
  output logic [1:0] dev_irq
);

  usbirq_word_t en_q [2];
  usbirq_addr_t addr_q [2];
  usbirq_word_t flags_q [2];
  usbirq_ep_t ep_num [2];
  logic [7:0] nak_en [2];
  usbirq_addr_t tok_addr [2];
  usbirq_word_t otg_set;
  usbirq_word_t next_rdata;
  logic otg_primed;
  logic vbus_q;
  logic id_q;

  assign ep_num[0] = ep_num_dev1;
  assign ep_num[1] = ep_num_dev2;
  assign nak_en[0] = nak_irq_en_dev1;
  assign nak_en[1] = nak_irq_en_dev2;
  assign tok_addr[0] = tok_addr_dev1;
  assign tok_addr[1] = tok_addr_dev2;

  // Edge history reloads every cycle and detection waits one cycle after reset, so a level present at release is not taken as an edge
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      otg_primed <= 1'b0;
      vbus_q <= 1'b0;
      id_q <= 1'b0;
    end
    else
    begin
      otg_primed <= 1'b1;
      vbus_q <= vbus_valid;
      id_q <= otg_id;
    end
  end

  always_comb
  begin
    otg_set = 16'h0000;
    otg_set[`USBIRQ_BIT_VBUS] = otg_primed && (vbus_valid != vbus_q);
    otg_set[`USBIRQ_BIT_ID] = otg_primed && (otg_id != id_q);
  end

  genvar d;
  generate
    for (d = 0; d < `USBIRQ_NUM_DEV; d = d + 1)
    begin : g_dev
      localparam bit IS_FIRST = (d == 0);
      localparam usbirq_word_t OFS_EN = IS_FIRST ? `USBIRQ_DEV1_IRQ_EN : `USBIRQ_DEV2_IRQ_EN;
      localparam usbirq_word_t OFS_ADDR = IS_FIRST ? `USBIRQ_DEV1_USB_ADDR : `USBIRQ_DEV2_USB_ADDR;
      localparam usbirq_word_t OFS_FLAGS = IS_FIRST ? `USBIRQ_DEV1_FLAGS : `USBIRQ_DEV2_FLAGS;
      localparam usbirq_word_t EN_MASK = IS_FIRST ? `USBIRQ_EN_MASK_OTG : `USBIRQ_EN_MASK_PLAIN;

      logic tx_done;
      usbirq_word_t ep_set;
      usbirq_word_t set_evt;

      // Reserved bits are dropped on write so they always read back as zero
      always_ff @(posedge clock)
      begin
        if (!rst_n)
        begin
          en_q[d] <= `USBIRQ_EN_RESET;
        end
        else if (reg_wr && (reg_addr == OFS_EN))
        begin
          en_q[d] <= reg_wdata & EN_MASK;
        end
      end

      always_ff @(posedge clock)
      begin
        if (!rst_n)
        begin
          addr_q[d] <= `USBIRQ_ADDR_RESET;
        end
        else if (reg_wr && (reg_addr == OFS_ADDR))
        begin
          addr_q[d] <= reg_wdata[6:0] & `USBIRQ_ADDR_MASK;
        end
      end

      // Foreign addresses simply never see a match, so the token is dropped silently
      assign tok_match[d] = tok_valid[d] && (tok_addr[d] == addr_q[d]);

      assign tx_done = ep_ack[d] || ep_stall[d] || ep_timeout[d] || ep_in_err[d] || ep_out_err[d]
                       || (ep_nak[d] && nak_en[d][ep_num[d]]);
      assign ep_set = tx_done ? (16'h0001 << ep_num[d]) : 16'h0000;

      always_comb
      begin
        set_evt = ep_set;
        set_evt[`USBIRQ_BIT_SOF_EOP] = sof_eop_rx[d];
        set_evt[`USBIRQ_BIT_BUS_RST] = bus_reset_det[d];
        if (IS_FIRST)
        begin
          set_evt = set_evt | otg_set;
        end
      end

      usbirq_flags #(
        .HAS_OTG(IS_FIRST)
      ) u_flags (
        .clock(clock),
        .rst_n(rst_n),
        .set_evt(set_evt),
        .clr_wr(reg_wr && (reg_addr == OFS_FLAGS)),
        .clr_data(reg_wdata),
        .flags(flags_q[d])
      );

      assign dev_irq[d] = |(flags_q[d] & en_q[d]);
    end
  endgenerate

  // Address registers are write-only and unmapped offsets read zero
  always_comb
  begin
    next_rdata = 16'h0000;
    case (reg_addr)
      `USBIRQ_DEV1_IRQ_EN: next_rdata = en_q[0];
      `USBIRQ_DEV1_FLAGS: next_rdata = flags_q[0];
      `USBIRQ_DEV2_IRQ_EN: next_rdata = en_q[1];
      `USBIRQ_DEV2_FLAGS: next_rdata = flags_q[1];
      default: next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 16'h0000;
    end
    else if (reg_rd)
    begin
      reg_rdata <= next_rdata;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_token_filter: assert property (tok_valid[0] |-> (tok_match[0] == (tok_addr_dev1 == addr_q[0])))
    else $error("token match disagrees with stored address");
  a_addr_reset: assert property (!$past(rst_n) |-> (addr_q[0] == 7'h00 && addr_q[1] == 7'h00))
    else $error("device address not zero after reset");
  a_addr_write: assert property ((reg_wr && reg_addr == `USBIRQ_DEV2_USB_ADDR) |=>
                                 (addr_q[1] == $past(reg_wdata[6:0])))
    else $error("address write not taken");
  a_done_sets: assert property ((ep_stall[0] || ep_timeout[0]) |=> flags_q[0][$past(ep_num_dev1)])
    else $error("transaction done did not set endpoint flag");
  a_nak_gated: assert property ((ep_nak[0] && nak_irq_en_dev1[ep_num_dev1])
                                |=> flags_q[0][$past(ep_num_dev1)])
    else $error("enabled nak did not set endpoint flag");
  a_vbus_edge: assert property ((otg_primed && $changed(vbus_valid)) |=> flags_q[0][15])
    else $error("vbus edge not flagged");
  a_id_edge: assert property ((otg_primed && $changed(otg_id)) |=> flags_q[0][14])
    else $error("id edge not flagged");
  a_dev2_no_otg: assert property (flags_q[1][15:14] == 2'b00)
    else $error("otg flag set in second device");
  a_sof_flag: assert property (sof_eop_rx[1] |=> flags_q[1][9] ##1 (flags_q[1][9] || $past(reg_wr)))
    else $error("sof flag not held");
  // A clear written in the cycle after the event may legally drop the request again
  a_reset_irq: assert property ((bus_reset_det[0] && en_q[0][8] && !reg_wr) |=>
                                dev_irq[0] ##1 (dev_irq[0] || $past(reg_wr)))
    else $error("bus reset interrupt not raised");
  a_en_gate: assert property ((en_q[0] == 16'h0000) |-> !dev_irq[0])
    else $error("interrupt raised with all enables off");
  a_read_flags: assert property ((reg_rd && reg_addr == `USBIRQ_DEV1_FLAGS) |=>
                                 (reg_rdata == $past(flags_q[0])))
    else $error("status read returned wrong value");
  a_ep_flag_view: assert property (ep_ack[1] |=> flags_q[1][$past(ep_num_dev2)])
    else $error("ack did not set endpoint flag");

  // Token filter and address write for both devices; write-only address read, enable write and masked paths for the first device only
  a_token_filter_b: assert property (tok_valid[1] |->
                                     (tok_match[1] == (tok_addr_dev2 == addr_q[1])))
    else $error("second token match disagrees with stored address");
  a_token_idle: assert property ((tok_valid == 2'b00) |->
                                 (tok_match == 2'b00))
    else $error("match raised without a token");
  a_addr_write_a: assert property ((reg_wr && reg_addr == `USBIRQ_DEV1_USB_ADDR) |=>
                                   (addr_q[0] == $past(reg_wdata[6:0])))
    else $error("first address write not taken");
  a_addr_keep: assert property (!(reg_wr && reg_addr == `USBIRQ_DEV2_USB_ADDR) |=>
                                (addr_q[1] == $past(addr_q[1])))
    else $error("address changed without a write");
  a_addr_read_zero: assert property ((reg_rd && reg_addr == `USBIRQ_DEV1_USB_ADDR) |=>
                                     (reg_rdata == 16'h0000))
    else $error("write-only address read back nonzero");
  a_read_flags_b: assert property ((reg_rd && reg_addr == `USBIRQ_DEV2_FLAGS) |=>
                                   (reg_rdata == $past(flags_q[1])))
    else $error("second status read returned wrong value");
  a_en_write: assert property ((reg_wr && reg_addr == `USBIRQ_DEV1_IRQ_EN) |=>
                               (en_q[0] == ($past(reg_wdata) & `USBIRQ_EN_MASK_OTG)))
    else $error("enable write not stored");
  a_ep_gate: assert property (((flags_q[0][5:0] & en_q[0][5:0]) != 6'h00) |->
                              dev_irq[0])
    else $error("enabled endpoint flag raised no interrupt");

  // Clearing every flag drops the request unless a new event lands in that same cycle
  a_irq_cleared: assert property ((reg_wr && reg_addr == `USBIRQ_DEV1_FLAGS &&
                                   reg_wdata == `USBIRQ_FLAG_MASK_OTG && g_dev[0].set_evt == 16'h0000)
                                  |=> !dev_irq[0])
    else $error("interrupt held after all flags cleared");
  a_nak_masked: assert property ((ep_nak[0] && !nak_irq_en_dev1[ep_num_dev1] &&
                                  !flags_q[0][ep_num_dev1] && !(ep_ack[0] || ep_stall[0] || ep_timeout[0] ||
                                  ep_in_err[0] || ep_out_err[0]))
                                 |=> !flags_q[0][$past(ep_num_dev1)])
    else $error("nak without its enable set an endpoint flag");
  a_sof_set_a: assert property (sof_eop_rx[0] |=> flags_q[0][9])
    else $error("sof event did not set flag");
  a_bus_rst_b: assert property (bus_reset_det[1] |=> flags_q[1][8])
    else $error("bus reset did not set flag");
  a_err_sets: assert property ((ep_in_err[1] || ep_out_err[1]) |=>
                               flags_q[1][$past(ep_num_dev2)])
    else $error("exception error did not set endpoint flag");

  // Quiet forms: a flag never rises without its own event
  a_sof_quiet: assert property ((!flags_q[1][9] && !sof_eop_rx[1]) |=>
                                !flags_q[1][9])
    else $error("sof flag rose without an event");
  a_rst_quiet: assert property ((!flags_q[0][8] && !bus_reset_det[0]) |=>
                                !flags_q[0][8])
    else $error("bus reset flag rose without an event");
  a_ep_quiet: assert property ((!flags_q[1][0] && !(ep_num_dev2 == 3'h0 &&
                               (ep_ack[1] || ep_stall[1] || ep_timeout[1] || ep_in_err[1] || ep_out_err[1] ||
                               ep_nak[1]))) |=> !flags_q[1][0])
    else $error("endpoint flag rose without a transaction");
  a_otg_quiet: assert property ((!flags_q[0][15] && !(otg_primed && $changed(vbus_valid))) |=>
                                !flags_q[0][15])
    else $error("vbus flag rose without an edge");

  c_irq_raised: cover property (ep_ack[0] ##1 dev_irq[0]);
  c_flag_cleared: cover property (flags_q[0][8] ##1 (reg_wr && reg_addr == `USBIRQ_DEV1_FLAGS) ##1 !flags_q[0][8]);
  c_token_hit: cover property (tok_match[1] && addr_q[1] != 7'h00);
  c_vbus_irq: cover property ($changed(vbus_valid) ##1 dev_irq[0]);
  c_dev2_reset: cover property (bus_reset_det[1] ##1 dev_irq[1]);

endmodule : usbirq_top

`default_nettype wire

// File: rtl/usbirq_map.svh
// Purpose: Register offsets, field positions, masks and reset values of the device interrupt block
// Assumes: 16-bit register words at fixed host port offsets
// Notes: Definitions only
`ifndef USBIRQ_MAP_SVH
`define USBIRQ_MAP_SVH

`define USBIRQ_NUM_DEV 2
`define USBIRQ_NUM_EP 8

`define USBIRQ_DEV1_IRQ_EN 16'hC08C
`define USBIRQ_DEV1_USB_ADDR 16'hC08E
`define USBIRQ_DEV1_FLAGS 16'hC090
`define USBIRQ_DEV2_IRQ_EN 16'hC0AC
`define USBIRQ_DEV2_USB_ADDR 16'hC0AE
`define USBIRQ_DEV2_FLAGS 16'hC0B0

`define USBIRQ_BIT_VBUS 15
`define USBIRQ_BIT_ID 14
`define USBIRQ_BIT_SOF_TMO 11
`define USBIRQ_BIT_SOF_EOP 9
`define USBIRQ_BIT_BUS_RST 8

`define USBIRQ_EN_MASK_OTG 16'hCBFF
`define USBIRQ_EN_MASK_PLAIN 16'h0BFF
`define USBIRQ_FLAG_MASK_OTG 16'hC3FF
`define USBIRQ_FLAG_MASK_PLAIN 16'h03FF
`define USBIRQ_ADDR_MASK 7'h7F

`define USBIRQ_EN_RESET 16'h0000
`define USBIRQ_ADDR_RESET 7'h00
`define USBIRQ_FLAG_RESET 16'h0000

`endif

// File: rtl/usbirq_pkg.sv
// Purpose: Shared types of the device interrupt and address block
// Assumes: Nothing beyond the register map header
// Notes: Types only; numbers live in the map header
package usbirq_pkg;

  typedef logic [15:0] usbirq_word_t;
  typedef logic [6:0] usbirq_addr_t;
  typedef logic [2:0] usbirq_ep_t;

endpackage : usbirq_pkg

// File: rtl/usbirq_flags.sv
// Purpose: Sticky event flags of one device with write-one-to-clear
// Assumes: Set events and clear writes are single-cycle pulses
// Notes: A set in the same cycle as its clear is kept
`timescale 1ns/1ps
`default_nettype none
`include "usbirq_map.svh"

module usbirq_flags
  import usbirq_pkg::*;
#(
  parameter bit HAS_OTG = 1'b1
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Events and clears
  input wire usbirq_word_t set_evt,
  input wire logic clr_wr,
  input wire usbirq_word_t clr_data,
  // Flag state
  output usbirq_word_t flags
);

  localparam usbirq_word_t FLAG_MASK = HAS_OTG ? `USBIRQ_FLAG_MASK_OTG : `USBIRQ_FLAG_MASK_PLAIN;

  usbirq_word_t clr_vec;
  usbirq_word_t next_flags;

  assign clr_vec = clr_wr ? clr_data : 16'h0000;
  // Set is OR-ed after the clear so a coincident event survives
  assign next_flags = ((flags & ~clr_vec) | set_evt) & FLAG_MASK;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      flags <= `USBIRQ_FLAG_RESET;
    end
    else
    begin
      flags <= next_flags;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_set_wins_clear: assert property ((set_evt[0] && clr_wr && clr_data[0]) |=> flags[0])
    else $error("event lost to a coincident clear");
  a_clear_by_one: assert property ((clr_wr && clr_data[8] && !set_evt[8]) |=> !flags[8])
    else $error("write of one did not clear flag");
  a_zero_keeps: assert property ((flags[1] && clr_wr && !clr_data[1]) |=> flags[1])
    else $error("write of zero changed a flag");
  a_reserved_quiet: assert property (flags[13:10] == 4'h0)
    else $error("reserved flag bit set");

endmodule : usbirq_flags

`default_nettype wire

// File: dv/usbirq_host_model.sv
// Purpose: Behavioural USB host side of the block: tokens, endpoint outcomes and bus events
// Assumes: Lines change on the falling edge; every event is a one-cycle pulse
// Notes: Released token and endpoint lines show the inverse of their last value, never a stale copy
`timescale 1ns/1ps
`default_nettype none

module usbirq_host_model
  import usbirq_pkg::*;
(
  // Clock
  input wire logic clock,
  // Tokens
  output logic [1:0] tok_valid,
  output usbirq_addr_t tok_addr_dev1,
  output usbirq_addr_t tok_addr_dev2,
  // Outcomes and bus events
  output usbirq_ep_t ep_num_dev1,
  output usbirq_ep_t ep_num_dev2,
  output logic [1:0] ep_ack,
  output logic [1:0] ep_stall,
  output logic [1:0] ep_timeout,
  output logic [1:0] ep_in_err,
  output logic [1:0] ep_out_err,
  output logic [1:0] ep_nak,
  output logic [1:0] sof_eop_rx,
  output logic [1:0] bus_reset_det
);
  logic [7:0] evt1 = 8'h00;
  logic [7:0] evt2 = 8'h00;

  // Kinds 0..5 are endpoint outcomes, 6 is SOF/EOP, 7 is bus reset
  assign ep_ack = {evt2[0], evt1[0]};
  assign ep_stall = {evt2[1], evt1[1]};
  assign ep_timeout = {evt2[2], evt1[2]};
  assign ep_in_err = {evt2[3], evt1[3]};
  assign ep_out_err = {evt2[4], evt1[4]};
  assign ep_nak = {evt2[5], evt1[5]};
  assign sof_eop_rx = {evt2[6], evt1[6]};
  assign bus_reset_det = {evt2[7], evt1[7]};

  initial
  begin
    tok_valid = 2'h0;
    tok_addr_dev1 = 7'h55;
    tok_addr_dev2 = 7'h2A;
    ep_num_dev1 = 3'h5;
    ep_num_dev2 = 3'h2;
  end

  // Returns one step after the edge so the caller sees the settled match
  task automatic token(input int dev, input usbirq_addr_t a);
    @(negedge clock);
    if (dev == 0)
      tok_addr_dev1 = a;
    else
      tok_addr_dev2 = a;
    tok_valid = 2'(1 << dev);
    #1;
  endtask : token

  task automatic tok_off();
    @(negedge clock);
    tok_valid = 2'h0;
    tok_addr_dev1 = ~tok_addr_dev1;
    tok_addr_dev2 = ~tok_addr_dev2;
  endtask : tok_off

  task automatic outcome(input int dev, input usbirq_ep_t ep, input int k);
    @(negedge clock);
    ep_num_dev1 = ep;
    ep_num_dev2 = ep;
    if (dev == 0)
      evt1 = 8'(1 << k);
    else
      evt2 = 8'(1 << k);
    @(negedge clock);
    evt1 = 8'h00;
    evt2 = 8'h00;
    ep_num_dev1 = ~ep;
    ep_num_dev2 = ~ep;
  endtask : outcome
endmodule : usbirq_host_model
`default_nettype wire

// File: dv/testbench.sv
// Purpose: Self-checking bench of the device interrupt and address block
// Assumes: Inputs change on the falling edge; the host model supplies bus traffic
// Notes: Fixed-seed random outcome mix plus hand-picked corner cases
`timescale 1ns/1ps
`default_nettype none
`include "usbirq_map.svh"

module testbench
  import usbirq_pkg::*;
  ;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  usbirq_word_t reg_addr = 16'h0000;
  usbirq_word_t reg_wdata = 16'h0000;
  logic [7:0] nak_irq_en_dev1 = 8'h00;
  logic [7:0] nak_irq_en_dev2 = 8'h00;
  logic vbus_valid = 1'h0;
  logic otg_id = 1'h0;
  usbirq_word_t reg_rdata;
  usbirq_addr_t tok_addr_dev1, tok_addr_dev2;
  usbirq_ep_t ep_num_dev1, ep_num_dev2;
  logic [1:0] tok_valid, tok_match, dev_irq, ep_ack, ep_stall, ep_timeout, ep_in_err, ep_out_err, ep_nak;
  logic [1:0] sof_eop_rx, bus_reset_det;
  int checks = 0;
  int failures = 0;
  usbirq_word_t en_off[2] = '{`USBIRQ_DEV1_IRQ_EN, `USBIRQ_DEV2_IRQ_EN};
  usbirq_word_t ad_off[2] = '{`USBIRQ_DEV1_USB_ADDR, `USBIRQ_DEV2_USB_ADDR};
  usbirq_word_t fl_off[2] = '{`USBIRQ_DEV1_FLAGS, `USBIRQ_DEV2_FLAGS};
  usbirq_word_t en_msk[2] = '{16'hCBFF, 16'h0BFF};
  usbirq_word_t fl_msk[2] = '{16'hC3FF, 16'h03FF};

  initial
  begin
    forever #2.5 clock = ~clock;
  end

  usbirq_host_model host (.clock, .tok_valid, .tok_addr_dev1, .tok_addr_dev2, .ep_num_dev1, .ep_num_dev2, .ep_ack,
    .ep_stall, .ep_timeout, .ep_in_err, .ep_out_err, .ep_nak, .sof_eop_rx, .bus_reset_det);

  usbirq_top dut (.clock, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .tok_valid, .tok_addr_dev1,
    .tok_addr_dev2, .tok_match, .ep_num_dev1, .ep_num_dev2, .ep_ack, .ep_stall, .ep_timeout, .ep_in_err,
    .ep_out_err, .ep_nak, .nak_irq_en_dev1, .nak_irq_en_dev2, .sof_eop_rx, .bus_reset_det, .vbus_valid, .otg_id,
    .dev_irq);

  task automatic check(input string name, input usbirq_word_t seen, input usbirq_word_t exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input usbirq_word_t a, input usbirq_word_t d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(negedge clock);
    reg_wr = 1'h0;
  endtask : wr

  task automatic rdchk(input string name, input usbirq_word_t a, input usbirq_word_t exp);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'h1;
    @(negedge clock);
    reg_rd = 1'h0;
    check(name, reg_rdata, exp);
  endtask : rdchk

  // A NAK only counts when that endpoint's NAK enable is set
  function automatic usbirq_word_t exp_flag(int ep, int k, logic [7:0] nak);
    if (k == 6)
      return 16'h0200;
    if (k == 7)
      return 16'h0100;
    if (k == 5 && !nak[ep])
      return 16'h0000;
    return 16'h0001 << ep;
  endfunction : exp_flag

  task automatic end_sim();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim

  initial
  begin
    #200000;
    failures++;
    end_sim();
  end

  initial
  begin
    usbirq_word_t e;
    usbirq_word_t en;
    usbirq_addr_t a;
    int dev;
    int ep;
    int k;
    repeat (12) @(posedge clock);
    @(negedge clock);
    rst_n = 1'h1;
    void'($urandom(32'h55A6));
    for (int i = 0; i < 2; i++)
    begin
      rdchk("flags", fl_off[i], 16'h0000);
      host.token(i, 7'h00);
      check("match", 16'(tok_match[i]), 16'h0001);
      wr(en_off[i], en_msk[i]);
      rdchk("en mask", en_off[i], en_msk[i]);
      repeat (3)
      begin
        a = 7'($urandom);
        wr(ad_off[i], {9'h000, a});
        rdchk("addr", ad_off[i], 16'h0000);
        host.token(i, a);
        check("match", 16'(tok_match[i]), 16'h0001);
        host.token(i, a ^ 7'h41);
        check("mismatch", 16'(tok_match[i]), 16'h0000);
        host.tok_off();
      end
    end
    for (int n = 0; n < 80; n++)
    begin
      dev = $urandom_range(1);
      ep = $urandom_range(7);
      k = (n < 16) ? n % 8 : $urandom_range(7);
      en = 16'($urandom) & en_msk[dev];
      wr(fl_off[dev], fl_msk[dev]);
      wr(en_off[dev], en);
      nak_irq_en_dev1 = 8'($urandom);
      nak_irq_en_dev2 = 8'($urandom);
      host.outcome(dev, 3'(ep), k);
      e = exp_flag(ep, k, dev ? nak_irq_en_dev2 : nak_irq_en_dev1);
      check("irq", 16'(dev_irq[dev]), 16'(|(e & en)));
      rdchk("flags", fl_off[dev], e);
      wr(fl_off[dev], ~e & fl_msk[dev]);
      rdchk("kept", fl_off[dev], e);
      wr(fl_off[dev], e);
      rdchk("cleared", fl_off[dev], 16'h0000);
      check("irq off", 16'(dev_irq[dev]), 16'h0000);
    end
    wr(en_off[0], 16'hC000);
    for (int j = 0; j < 4; j++)
    begin
      wr(fl_off[0], fl_msk[0]);
      if (j < 2)
        vbus_valid = ~vbus_valid;
      else
        otg_id = ~otg_id;
      @(negedge clock);
      check("otg irq", 16'(dev_irq[0]), 16'h0001);
      rdchk("otg flag", fl_off[0], (j < 2) ? 16'h8000 : 16'h4000);
      rdchk("dev2 otg", fl_off[1], 16'h0000);
    end
    // A level already high at release must not read as an edge afterwards
    rst_n = 1'h0;
    vbus_valid = 1'h1;
    repeat (2) @(negedge clock);
    rst_n = 1'h1;
    rdchk("rst flags", fl_off[0], 16'h0000);
    rdchk("rst en", en_off[0], 16'h0000);
    for (int i = 0; i < 2; i++)
    begin
      host.token(i, 7'h00);
      check("rst match", 16'(tok_match[i]), 16'h0001);
    end
    host.tok_off();
    rdchk("unmapped", 16'hC092, 16'h0000);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
